// file: core/ppcb_regs.vh
// Purpose: Constants for the parallel port configuration bank.
// Assumes: Register indices are kept as printed; byte address is four times the index.
// Notes:   Widths of macros match the signals they meet.
`ifndef PPCB_REGS_VH
`define PPCB_REGS_VH

// Register indices (APB byte address = index * 4)
`define PPCB_IDX_ACTIVATE      8'h30
`define PPCB_IDX_BASE_HIGH     8'h60
`define PPCB_IDX_BASE_LOW      8'h61
`define PPCB_IDX_IRQ_WAKE      8'h70
`define PPCB_IDX_IRQ_TYPE      8'h71
`define PPCB_IDX_DMA_SELECT    8'h74
`define PPCB_IDX_DMA_SECOND    8'h75
`define PPCB_IDX_PORT_CFG      8'hF0

// Reset values
`define PPCB_RST_ACTIVATE      8'h00
`define PPCB_RST_BASE_HIGH     8'h02
`define PPCB_RST_BASE_LOW      8'h78
`define PPCB_RST_IRQ_WAKE      8'h07
`define PPCB_RST_IRQ_TYPE      8'h02
`define PPCB_RST_DMA_SELECT    8'h04
`define PPCB_VAL_DMA_SECOND    8'h04
`define PPCB_RST_PORT_CFG      8'hF2

// Writable bit masks; zero bits are read-only zero, except interrupt type bit 0, which reads the live mode
`define PPCB_WMSK_BASE_HIGH    8'h07
`define PPCB_WMSK_BASE_LOW     8'hFC
`define PPCB_WMSK_IRQ_TYPE     8'h02
`define PPCB_WMSK_PORT_CFG     8'hF3

// Port configuration field positions
`define PPCB_CFG_MODE_HI       7
`define PPCB_CFG_MODE_LO       5
`define PPCB_CFG_EXT_ACCESS    4
`define PPCB_CFG_CLK_ON        1
`define PPCB_CFG_HIZ_EN        0
`define PPCB_ACT_BIT           0
`define PPCB_ITYPE_LEVEL       0

// Configured mode select encodings
`define PPCB_MODE_SPP          3'h0
`define PPCB_MODE_SPP_EXT      3'h1
`define PPCB_MODE_EPP17        3'h2
`define PPCB_MODE_EPP19        3'h3
`define PPCB_MODE_ECP          3'h4
`define PPCB_MODE_RSV5         3'h5
`define PPCB_MODE_RSV6         3'h6
`define PPCB_MODE_ECP_EPP      3'h7

// Runtime mode control field value that means EPP (mode 4)
`define PPCB_RT_MODE_EPP       3'h4

`endif

// file: core/ppcb_config_bank.v
// Purpose: Configuration register bank of the parallel port logical device, APB slave.
// Assumes: Single clock pclk at 25 MHz; runtime inputs come from logic on pclk.
// Notes:   Zero wait state APB; read data is prepared in the setup cycle.
//
// Notes on behaviour
// - Activation register at index 30h, read/write, resets to 00h.
// - Base high byte resets 02h; bits 7-3 read-only, always zero.
// - Base low byte resets 78h; bits 1-0 read-only, always zero.
// - Interrupt number and wake register at 70h, read/write, resets 07h.
// - Interrupt type resets 02h; bit 1 writable, bits 7-2 read-only. Here it reads 03h after reset, bit 0 showing the default extended mode.
// - Interrupt type bit 0 reads 1 in extended mode, else 0.
// - DMA select at 74h resets 04h; 75h reads fixed 04h.
// - Port configuration register at F0h resets to F2h.
// - Bits 7-5 select SPP, SPP extended, EPP 1.7/1.9, ECP variants.
// - In ECP mode 4, EPP version follows second-level control bit 4.
// - Bit 4 clear blocks runtime registers 403h-405h; set grants access.
// - Bit 1 clear stops port clock; ECP and EPP timeout halt.
// - Bit 1 set (default) runs port clock while device active.
// - Bit 0 set with device inactive floats port outputs; default off.
// - Active runtime mode comes from the runtime mode control register.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "ppcb_regs.vh"

// Bus timing in brief:
// A transfer takes two cycles and the slave never stretches it.
// The setup cycle selects the register and prepares the answer.
// The access cycle shows pready, prdata and pslverr for one cycle.
// A write lands on the edge that closes the access cycle.
// Back to back transfers are accepted without an idle cycle.
// Only byte lane 0 carries data; the upper lanes read as zero.
// Misaligned or unmapped addresses answer with pslverr and store nothing.
//
// Runtime side in brief:
// Mode, clock and access controls are offered as registered levels.
// Runtime inputs share pclk, so they are used without synchronisers.
// Every derived output follows its source one edge later.

module ppcb_config_bank #(
   parameter ADDR_W = 10
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   input  wire [3:0]        pstrb,
   output wire [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   input  wire [2:0]        runtime_mode_control,
   input  wire              second_level_ext_control_b,
   input  wire              ext_reg_request,
   output wire [15:0]       base_address,
   output wire [7:0]        irq_number_wake,
   output wire [7:0]        dma_channel,
   output wire              device_active,
   output wire [2:0]        port_mode,
   output wire              epp_enabled,
   output wire              epp_v19_select,
   output wire              ecp_enabled,
   output wire              epp_timeout_enable,
   output wire              port_clock_enable,
   output wire              ext_regs_enable,
   output wire              ext_reg_grant,
   output wire              outputs_hiz
);

   // Register storage.
   // Read-only bits are never stored as ones, and reads mask them a second time.
   // Only bit 1 of the interrupt type is kept; bit 0 is derived live.
   // The second DMA report is a constant and has no storage at all.
   // Reserved configuration bits are held at zero by the write mask.
   reg [7:0]  activate_ff;
   reg [7:0]  base_high_ff;
   reg [7:0]  base_low_ff;
   reg [7:0]  irq_wake_ff;
   reg        irq_type_b1_ff;
   reg [7:0]  dma_select_ff;
   reg [7:0]  port_cfg_ff;

   // Bus answer flops
   reg [31:0] prdata_ff;
   reg [31:0] nxt_prdata;
   reg        pready_ff;
   reg        pslverr_ff;
   reg        nxt_pslverr;

   // Derived output flops
   reg [15:0] base_address_ff;
   reg        device_active_ff;
   reg [2:0]  port_mode_ff;
   reg        epp_enabled_ff;
   reg        nxt_epp_enabled;
   reg        epp_v19_ff;
   reg        nxt_epp_v19;
   reg        ecp_enabled_ff;
   reg        nxt_ecp_enabled;
   reg        epp_timeout_ff;
   reg        port_clock_ff;
   reg        ext_regs_ff;
   reg        ext_grant_ff;
   reg        hiz_ff;

   // Decode helpers
   reg        hit_map;
   reg [7:0]  rd_byte;
   wire [7:0] reg_index;
   wire       aligned;
   wire       setup_phase;
   wire       wr_commit;
   wire       lane0_wr;
   wire [7:0] wbyte;
   wire [7:0] irq_type_view;
   wire [2:0] cfg_mode;
   wire       cfg_ecp_family;
   wire       ext_mode;
   wire       clk_on_next;

   assign reg_index   = paddr[9:2];
   assign aligned     = (paddr[1:0] == 2'h0);
   assign setup_phase = psel & ~penable;
   // Write lands only on the access edge where pready is sampled high
   assign wr_commit   = psel & penable & pready_ff & pwrite & ~pslverr_ff;
   // Registers are one byte wide and live on byte lane 0
   assign lane0_wr    = wr_commit & pstrb[0];
   assign wbyte       = pwdata[7:0];

   assign cfg_mode       = port_cfg_ff[`PPCB_CFG_MODE_HI:`PPCB_CFG_MODE_LO];
   assign cfg_ecp_family = (cfg_mode == `PPCB_MODE_ECP) | (cfg_mode == `PPCB_MODE_ECP_EPP);
   // Extended mode: ECP register set with the extended registers switched on
   assign ext_mode       = cfg_ecp_family & port_cfg_ff[`PPCB_CFG_EXT_ACCESS];
   // Bit 0 is a live view of the mode, never stored
   assign irq_type_view  = {6'h00, irq_type_b1_ff, ext_mode};

   // Read mux and map check, evaluated during the setup cycle.
   // An if chain keeps the decode priority explicit and easy to extend.
   // Default values at the top keep the process free of latches.
   // A misaligned address overrides any hit, so low bits never alias.
   // Read data for an error answer is forced to zero.
   always @* begin
      hit_map = 1'b1;
      rd_byte = 8'h00;
      if (reg_index == `PPCB_IDX_ACTIVATE) begin
         rd_byte = activate_ff;
      end else if (reg_index == `PPCB_IDX_BASE_HIGH) begin
         rd_byte = base_high_ff & `PPCB_WMSK_BASE_HIGH;
      end else if (reg_index == `PPCB_IDX_BASE_LOW) begin
         rd_byte = base_low_ff & `PPCB_WMSK_BASE_LOW;
      end else if (reg_index == `PPCB_IDX_IRQ_WAKE) begin
         rd_byte = irq_wake_ff;
      end else if (reg_index == `PPCB_IDX_IRQ_TYPE) begin
         rd_byte = irq_type_view;
      end else if (reg_index == `PPCB_IDX_DMA_SELECT) begin
         rd_byte = dma_select_ff;
      end else if (reg_index == `PPCB_IDX_DMA_SECOND) begin
         rd_byte = `PPCB_VAL_DMA_SECOND;
      end else if (reg_index == `PPCB_IDX_PORT_CFG) begin
         rd_byte = port_cfg_ff & `PPCB_WMSK_PORT_CFG;
      end else begin
         hit_map = 1'b0;
      end
      if (!aligned) begin
         hit_map = 1'b0;
         rd_byte = 8'h00;
      end
   end

   // Answer values for the coming access cycle
   always @* begin
      nxt_prdata  = {24'h000000, rd_byte};
      nxt_pslverr = ~hit_map;
      if (pwrite) begin
         nxt_prdata = 32'h00000000;
      end
   end

   // APB answer: ready in the first access cycle, so zero wait states.
   // Answer flops are cleared outside the access cycle so that stale
   // read data never lingers on the bus between transfers.
   // Trade-off: one flop stage of answer costs area but keeps outputs clean.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
      end else begin
         pready_ff <= setup_phase;
         if (setup_phase) begin
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
         end else begin
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
         end
      end
   end

   // Register writes; read-only bits are masked away before storage.
   // Writes to the fixed DMA report index are accepted without error
   // but change nothing, since that register has no storage.
   // A write with lane 0 strobe low is acknowledged and dropped.
   // Mode writes are taken as given; software must prepare the port first.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         activate_ff    <= `PPCB_RST_ACTIVATE;
         base_high_ff   <= `PPCB_RST_BASE_HIGH;
         base_low_ff    <= `PPCB_RST_BASE_LOW;
         irq_wake_ff    <= `PPCB_RST_IRQ_WAKE;
         irq_type_b1_ff <= 1'b1;
         dma_select_ff  <= `PPCB_RST_DMA_SELECT;
         port_cfg_ff    <= `PPCB_RST_PORT_CFG;
      end else if (lane0_wr) begin
         if (reg_index == `PPCB_IDX_ACTIVATE) begin
            activate_ff <= wbyte;
         end else if (reg_index == `PPCB_IDX_BASE_HIGH) begin
            base_high_ff <= wbyte & `PPCB_WMSK_BASE_HIGH;
         end else if (reg_index == `PPCB_IDX_BASE_LOW) begin
            base_low_ff <= wbyte & `PPCB_WMSK_BASE_LOW;
         end else if (reg_index == `PPCB_IDX_IRQ_WAKE) begin
            irq_wake_ff <= wbyte;
         end else if (reg_index == `PPCB_IDX_IRQ_TYPE) begin
            irq_type_b1_ff <= wbyte[1];
         end else if (reg_index == `PPCB_IDX_DMA_SELECT) begin
            dma_select_ff <= wbyte;
         end else if (reg_index == `PPCB_IDX_PORT_CFG) begin
            port_cfg_ff <= wbyte & `PPCB_WMSK_PORT_CFG;
         end
      end
   end

   // Mode decode is purely combinational and registered further down.
   // Only the combined ECP with EPP code looks at the runtime mode field;
   // in the other codes the runtime field has no say over EPP.
   // The EPP version in that code follows the second-level control bit.
   // Mode decode. Reserved codes enable neither EPP nor ECP, so the port
   // falls back to plain compatible behaviour rather than guessing.
   always @* begin
      nxt_epp_enabled = 1'b0;
      nxt_epp_v19     = 1'b0;
      nxt_ecp_enabled = 1'b0;
      case (cfg_mode)
         `PPCB_MODE_EPP17: begin
            nxt_epp_enabled = 1'b1;
         end
         `PPCB_MODE_EPP19: begin
            nxt_epp_enabled = 1'b1;
            nxt_epp_v19     = 1'b1;
         end
         `PPCB_MODE_ECP: begin
            nxt_ecp_enabled = 1'b1;
         end
         `PPCB_MODE_ECP_EPP: begin
            nxt_ecp_enabled = 1'b1;
            // EPP only when the runtime mode field asks for mode 4
            if (runtime_mode_control == `PPCB_RT_MODE_EPP) begin
               nxt_epp_enabled = 1'b1;
               nxt_epp_v19     = second_level_ext_control_b;
            end
         end
         default: begin
            nxt_epp_enabled = 1'b0;
         end
      endcase
   end

   // Port clock runs only while active with the clock bit set.
   // Stopping it never touches register contents here; only the
   // clock-dependent functions are switched off downstream.
   assign clk_on_next = activate_ff[`PPCB_ACT_BIT] & port_cfg_ff[`PPCB_CFG_CLK_ON];

   // Registered view of configuration for the runtime datapath.
   // Costs one cycle of latency after a write but keeps outputs glitch free.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_address_ff  <= 16'h0000;
         device_active_ff <= 1'b0;
         port_mode_ff     <= `PPCB_MODE_SPP;
         epp_enabled_ff   <= 1'b0;
         epp_v19_ff       <= 1'b0;
         ecp_enabled_ff   <= 1'b0;
         epp_timeout_ff   <= 1'b0;
         port_clock_ff    <= 1'b0;
         ext_regs_ff      <= 1'b0;
         ext_grant_ff     <= 1'b0;
         hiz_ff           <= 1'b0;
      end else begin
         // Upper five address lines are always zero
         base_address_ff  <= {5'h00, base_high_ff[2:0], base_low_ff[7:2], 2'h0};
         device_active_ff <= activate_ff[`PPCB_ACT_BIT];
         port_mode_ff     <= cfg_mode;
         epp_enabled_ff   <= nxt_epp_enabled;
         epp_v19_ff       <= nxt_epp_v19;
         // ECP and EPP timeout need the port clock; registers keep their contents
         ecp_enabled_ff   <= nxt_ecp_enabled & clk_on_next;
         epp_timeout_ff   <= nxt_epp_enabled & clk_on_next;
         port_clock_ff    <= clk_on_next;
         ext_regs_ff      <= port_cfg_ff[`PPCB_CFG_EXT_ACCESS];
         // Runtime accesses to 403h-405h are dropped while access is off
         ext_grant_ff     <= ext_reg_request & port_cfg_ff[`PPCB_CFG_EXT_ACCESS];
         hiz_ff           <= port_cfg_ff[`PPCB_CFG_HIZ_EN] & ~activate_ff[`PPCB_ACT_BIT];
      end
   end

   // Outputs straight from flops.
   // Interrupt number and DMA channel are the registers themselves, so they
   // follow a write on the same edge as the read-back does.
   // The high impedance request is a level; the pad logic acts on it.
   // Outputs straight from flops
   assign prdata             = prdata_ff;
   assign pready             = pready_ff;
   assign pslverr            = pslverr_ff;
   assign base_address       = base_address_ff;
   assign irq_number_wake    = irq_wake_ff;
   assign dma_channel        = dma_select_ff;
   assign device_active      = device_active_ff;
   assign port_mode          = port_mode_ff;
   assign epp_enabled        = epp_enabled_ff;
   assign epp_v19_select     = epp_v19_ff;
   assign ecp_enabled        = ecp_enabled_ff;
   assign epp_timeout_enable = epp_timeout_ff;
   assign port_clock_enable  = port_clock_ff;
   assign ext_regs_enable    = ext_regs_ff;
   assign ext_reg_grant      = ext_grant_ff;
   assign outputs_hiz        = hiz_ff;

endmodule // ppcb_config_bank

// file: verif/ppcb_config_bank_properties.sv
// Purpose: Temporal checks on the outputs of the parallel port configuration bank.
// Assumes: One clock pclk; presetn asynchronous and active low.
// Notes:   Derived outputs all lag their sources by one edge, so they agree among themselves.
`timescale 1ns/100ps
module ppcb_config_bank_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [2:0]  runtime_mode_control,
   input wire logic        second_level_ext_control_b,
   input wire logic        ext_reg_request,
   input wire logic [15:0] base_address,
   input wire logic        device_active,
   input wire logic [2:0]  port_mode,
   input wire logic        epp_enabled,
   input wire logic        epp_v19_select,
   input wire logic        ecp_enabled,
   input wire logic        epp_timeout_enable,
   input wire logic        port_clock_enable,
   input wire logic        ext_regs_enable,
   input wire logic        ext_reg_grant,
   input wire logic        outputs_hiz
);
   // One domain, so clock and reset are given once
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_base; base_address[15:11] == 5'h00 && base_address[1:0] == 2'h0; endproperty
   a_base: assert property (p_base) else $error("base address fixed bits not zero");
   property p_hiz; outputs_hiz |-> !device_active; endproperty
   a_hiz: assert property (p_hiz) else $error("outputs floated while active");
   property p_clk; port_clock_enable |-> device_active; endproperty
   a_clk: assert property (p_clk) else $error("port clock runs while inactive");
   property p_ecp;
      ecp_enabled == (port_clock_enable && (port_mode == 3'h4 || port_mode == 3'h7));
   endproperty
   a_ecp: assert property (p_ecp) else $error("ecp enable wrong");
   property p_eto; epp_timeout_enable == (epp_enabled && port_clock_enable); endproperty
   a_eto: assert property (p_eto) else $error("epp timeout enable wrong");
   // Runtime inputs are seen one edge late, hence the past value
   property p_epp;
      epp_enabled == (port_mode == 3'h2 || port_mode == 3'h3 ||
                      (port_mode == 3'h7 && $past(runtime_mode_control) == 3'h4));
   endproperty
   a_epp: assert property (p_epp) else $error("epp enable wrong");
   property p_v19;
      epp_v19_select == (port_mode == 3'h3 || (port_mode == 3'h7 &&
         $past(runtime_mode_control) == 3'h4 && $past(second_level_ext_control_b)));
   endproperty
   a_v19: assert property (p_v19) else $error("epp version select wrong");
   property p_grant; ext_reg_grant == ($past(ext_reg_request) && ext_regs_enable); endproperty
   a_grant: assert property (p_grant) else $error("extended register grant wrong");

   c_grant: cover property (ext_reg_grant);
   c_ecp: cover property (ecp_enabled && epp_timeout_enable);
   c_hiz: cover property (outputs_hiz);
endmodule // ppcb_config_bank_properties

// file: verif/ppcb_config_bank_tb_top.sv
// Purpose: Self-checking bench for the parallel port configuration bank.
// Assumes: Zero wait state APB slave; byte address is four times the index.
// Notes:   Derived outputs are checked at least three edges after the write lands.
`timescale 1ns/100ps
module ppcb_config_bank_tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [9:0]  paddr = 10'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [2:0]  rt = 3'h0;
   logic        ctl_b = 1'b0;
   logic        ext_req = 1'b0;
   wire  [31:0] prdata;
   wire  [15:0] base_address;
   wire  [2:0]  port_mode;
   wire  [7:0]  irq_w;
   wire  [7:0]  dma_w;
   wire         pready, pslverr, dev_act, epp_en, v19, ecp_en, eto_en, clk_en, ext_en, grant, hiz;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          cyc = 0;

   ppcb_config_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .runtime_mode_control(rt),
      .second_level_ext_control_b(ctl_b), .ext_reg_request(ext_req),
      .base_address(base_address), .irq_number_wake(irq_w), .dma_channel(dma_w),
      .device_active(dev_act),
      .port_mode(port_mode), .epp_enabled(epp_en), .epp_v19_select(v19), .ecp_enabled(ecp_en),
      .epp_timeout_enable(eto_en), .port_clock_enable(clk_en), .ext_regs_enable(ext_en),
      .ext_reg_grant(grant), .outputs_hiz(hiz));

   // Clock and hang guard; the whole run needs well under a thousand cycles
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   task report_and_stop();
      $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer; held until pready is sampled, then an idle cycle so psel is never
   // assigned twice in one time step
   task apb(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] r,
            output logic e);
      int n;
      psel <= 1'b1; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask

   task wr(input logic [7:0] i, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, i, d, r, e);
   endtask

   task rd(input logic [7:0] i, input logic [7:0] x, input logic xe = 1'b0);
      logic [31:0] r;
      logic        e;
      apb(1'b0, i, 8'h00, r, e);
      chk("prdata", {24'h000000, x}, r);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask

   task t_reset();
      rd(8'h30, 8'h00); rd(8'h60, 8'h02); rd(8'h61, 8'h78); rd(8'h70, 8'h07);
      rd(8'h71, 8'h03); rd(8'h74, 8'h04); rd(8'h75, 8'h04); rd(8'hF0, 8'hF2);
      chk("base_address", 32'h00000278, {16'h0, base_address});
      chk("irq_number_wake", 32'h00000007, {24'h0, irq_w});
      chk("dma_channel", 32'h00000004, {24'h0, dma_w});
      chk("device_active", 32'h0, {31'h0, dev_act});
      $display("reset values done");
   endtask

   // Read-only bits, the fixed register and an unmapped index. The device is
   // activated before any mode write; the port control setup lives in the datapath.
   task t_ro();
      wr(8'h30, 8'hFF); rd(8'h30, 8'hFF); rd(8'h31, 8'h00, 1'b1);
      // Address line 10 and 2 stay zero as software is expected to keep them
      wr(8'h60, 8'hFB); rd(8'h60, 8'h03); wr(8'h61, 8'hFB); rd(8'h61, 8'hF8);
      wr(8'h71, 8'hFC); rd(8'h71, 8'h01); wr(8'h75, 8'h00); rd(8'h75, 8'h04);
      wr(8'hF0, 8'hFF); rd(8'hF0, 8'hF3); wr(8'h70, 8'hA5); rd(8'h70, 8'hA5);
      wr(8'h74, 8'h5A); rd(8'h74, 8'h5A);
      chk("base_address", 32'h000003F8, {16'h0, base_address});
      chk("irq_number_wake", 32'h000000A5, {24'h0, irq_w});
      chk("dma_channel", 32'h0000005A, {24'h0, dma_w});
      chk("device_active", 32'h1, {31'h0, dev_act});
      $display("read-only bits done");
   endtask

   // Every mode code with the device active, runtime mode 4 and version bit set
   task t_modes();
      logic [2:0] m;
      rt <= 3'h4; ctl_b <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         m = k[2:0];
         wr(8'hF0, {m, 5'h12});
         rd(8'h71, {7'h0, m == 3'h4 || m == 3'h7});
         chk("port_mode", {29'h0, m}, {29'h0, port_mode});
         chk("epp", {31'h0, m == 3'h2 || m == 3'h3 || m == 3'h7}, {31'h0, epp_en});
         chk("eto", {31'h0, m == 3'h2 || m == 3'h3 || m == 3'h7}, {31'h0, eto_en});
         chk("v19", {31'h0, m == 3'h3 || m == 3'h7}, {31'h0, v19});
         chk("ecp", {31'h0, m == 3'h4 || m == 3'h7}, {31'h0, ecp_en});
      end
      rt <= 3'h0;
      tick(2);
      chk("epp", 32'h0, {31'h0, epp_en});
      $display("mode select done");
   endtask

   task t_clk();
      wr(8'hF0, 8'hF0); rd(8'hF0, 8'hF0); rd(8'h70, 8'hA5);
      chk("clock", 32'h0, {31'h0, clk_en}); chk("ecp", 32'h0, {31'h0, ecp_en});
      wr(8'hF0, 8'hF2); tick(2);
      chk("clock", 32'h1, {31'h0, clk_en}); chk("ecp", 32'h1, {31'h0, ecp_en});
      $display("port clock done");
   endtask

   task t_ext();
      ext_req <= 1'b1;
      wr(8'hF0, 8'hE2); tick(2);
      chk("grant", 32'h0, {31'h0, grant}); chk("ext_en", 32'h0, {31'h0, ext_en});
      wr(8'hF0, 8'hF2); tick(2);
      chk("grant", 32'h1, {31'h0, grant});
      ext_req <= 1'b0;
      $display("extended access done");
   endtask

   task t_hiz();
      wr(8'hF0, 8'hF3); tick(2);
      chk("hiz", 32'h0, {31'h0, hiz});
      wr(8'h30, 8'h00); tick(2);
      chk("hiz", 32'h1, {31'h0, hiz}); chk("clock", 32'h0, {31'h0, clk_en});
      chk("device_active", 32'h0, {31'h0, dev_act});
      $display("high impedance done");
   endtask

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_ro();
      t_modes();
      t_clk();
      t_ext();
      t_hiz();
      report_and_stop();
   end
endmodule // ppcb_config_bank_tb_top

bind ppcb_config_bank ppcb_config_bank_properties u_chk (.pclk(pclk), .presetn(presetn),
   .runtime_mode_control(runtime_mode_control), .ext_reg_request(ext_reg_request),
   .second_level_ext_control_b(second_level_ext_control_b), .base_address(base_address),
   .device_active(device_active), .port_mode(port_mode), .epp_enabled(epp_enabled),
   .epp_v19_select(epp_v19_select), .ecp_enabled(ecp_enabled), .outputs_hiz(outputs_hiz),
   .epp_timeout_enable(epp_timeout_enable), .port_clock_enable(port_clock_enable),
   .ext_regs_enable(ext_regs_enable), .ext_reg_grant(ext_reg_grant));
